// file: hw/rdms_top.sv
`timescale 1ns/10ps
`default_nettype none
module rdms_top (
    // Clock and power-on reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // External pins
    input wire logic i_ext_reset_n,
    input wire logic i_test_port_mode_strap,
    input wire logic i_test_reset_n,
    // Stability reports
    input wire logic i_osc_stable,
    input wire logic i_flash_stable,
    // Other reset sources and per-domain control
    input wire logic i_soft_reset,
    input wire logic i_watchdog_reset,
    input wire logic [rdms_pkg::NUM_DOMAINS-1:0] i_domain_reset_req,
    // Outputs
    output logic o_chip_reset,
    output logic [rdms_pkg::NUM_DOMAINS-1:0] o_domain_reset,
    output logic o_scan_reset,
    output rdms_pkg::rdms_mode_t o_mode,
    output logic [3:0] o_reset_cause
);
    ////////////////////////////////////////////////////////////////////////
    // Reset requests from the pin and the internal sources
    rdms_pkg::rdms_req_t req;
    logic chip_req;
    logic stable;

    always_comb begin
        req.external = ~i_ext_reset_n;
        req.software = i_soft_reset;
        req.watchdog = i_watchdog_reset;
    end

    always_comb begin
        chip_req = req.external | req.software | req.watchdog;
        stable = i_osc_stable & i_flash_stable;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    rdms_pkg::rdms_state_t state_r;
    rdms_pkg::rdms_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            rdms_pkg::RDMS_ASSERT: begin
                if (!chip_req) begin
                    state_nxt = rdms_pkg::RDMS_WAIT_STABLE;
                end
            end
            rdms_pkg::RDMS_WAIT_STABLE: begin
                if (chip_req) begin
                    state_nxt = rdms_pkg::RDMS_ASSERT;
                end else if (stable) begin
                    state_nxt = rdms_pkg::RDMS_RUN;
                end
            end
            rdms_pkg::RDMS_RUN: begin
                if (chip_req) begin
                    state_nxt = rdms_pkg::RDMS_ASSERT;
                end
            end
            default: begin
                state_nxt = rdms_pkg::RDMS_ASSERT;
            end
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_r <= rdms_pkg::STATE_AFTER_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strap sampled while the external reset is held
    logic strap_r;
    logic strap_nxt;

    always_comb begin
        strap_nxt = strap_r;
        // Last value seen before the pin rises is kept
        if (req.external) begin
            strap_nxt = i_test_port_mode_strap;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            strap_r <= rdms_pkg::STRAP_AFTER_RESET;
        end else begin
            strap_r <= strap_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Start-up mode decoded from the strap
    logic clk_sel_nxt;
    rdms_pkg::rdms_mode_t mode_r;
    rdms_pkg::rdms_mode_t mode_nxt;

    always_comb begin
        clk_sel_nxt = rdms_pkg::CLK_SEL_RING;
        if (!strap_nxt) begin
            clk_sel_nxt = rdms_pkg::CLK_SEL_CRYSTAL;
        end
    end

    always_comb begin
        mode_nxt.system_base_clock_crystal = clk_sel_nxt;
        mode_nxt.debug_mode = ~strap_nxt;
        mode_nxt.boundary_scan_mode = strap_nxt;
    end

    // Loaded with the strap, so the clock is set before release
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            mode_r <= rdms_pkg::MODE_AFTER_RESET;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Most recent reset source
    logic [3:0] cause_r;
    logic [3:0] cause_nxt;
    logic [3:0] cause_seen;

    always_comb begin
        // Sources active together are all recorded
        cause_seen = rdms_pkg::CAUSE_RESET;
        if (req.external) begin
            cause_seen = cause_seen | rdms_pkg::CAUSE_EXTERNAL;
        end
        if (req.software) begin
            cause_seen = cause_seen | rdms_pkg::CAUSE_SOFTWARE;
        end
        if (req.watchdog) begin
            cause_seen = cause_seen | rdms_pkg::CAUSE_WATCHDOG;
        end
    end

    always_comb begin
        cause_nxt = cause_r;
        if (chip_req) begin
            cause_nxt = cause_seen;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            cause_r <= rdms_pkg::CAUSE_POWER_UP;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test logic reset, independent of the chip reset
    logic scan_rst_r;
    logic scan_rst_nxt;

    always_comb begin
        scan_rst_nxt = ~i_test_reset_n;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            scan_rst_r <= rdms_pkg::SCAN_RESET_AFTER_RESET;
        end else begin
            scan_rst_r <= scan_rst_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset fan-out
    logic chip_hold;
    logic [rdms_pkg::NUM_DOMAINS-1:0] dom_hold;

    always_comb begin
        // Held while sequencing, and at once on a new request
        chip_hold = (state_r != rdms_pkg::RDMS_RUN) | chip_req;
    end

    always_comb begin
        // Each domain can also be held on its own
        dom_hold = i_domain_reset_req;
        if (chip_hold) begin
            dom_hold = '1;
        end
    end

    // The chip and each domain release walk through their own synchroniser
    rdms_sync u_chip_sync (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_assert(chip_hold),
        .o_reset(o_chip_reset)
    );

    genvar g;
    generate
        for (g = 0; g < rdms_pkg::NUM_DOMAINS; g++) begin : g_dom
            rdms_sync u_dom_sync (
                .i_core_clk(i_core_clk),
                .i_reset(i_reset),
                .i_assert(dom_hold[g]),
                .o_reset(o_domain_reset[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_scan_reset = scan_rst_r;
    assign o_reset_cause = cause_r;
    assign o_mode = mode_r;
endmodule
`default_nettype wire

// file: hw/rdms_pkg.sv
`default_nettype none
package rdms_pkg;
    localparam int NUM_DOMAINS = 8;
    localparam int SYNC_STAGES = 2;
    localparam logic [3:0] CAUSE_RESET = 4'h0;
    localparam logic [3:0] CAUSE_POWER_UP = 4'h1;
    localparam logic [3:0] CAUSE_EXTERNAL = 4'h2;
    localparam logic [3:0] CAUSE_SOFTWARE = 4'h4;
    localparam logic [3:0] CAUSE_WATCHDOG = 4'h8;
    localparam logic CLK_SEL_RING = 1'b0;
    localparam logic CLK_SEL_CRYSTAL = 1'b1;
    localparam logic MODE_DEBUG_RESET = 1'b1;
    localparam logic STRAP_AFTER_RESET = 1'h1;
    localparam logic SCAN_RESET_AFTER_RESET = 1'h1;

    typedef enum logic [1:0] {
        RDMS_ASSERT,
        RDMS_WAIT_STABLE,
        RDMS_RUN
    } rdms_state_t;

    localparam rdms_state_t STATE_AFTER_RESET = RDMS_ASSERT;

    typedef struct packed {
        logic system_base_clock_crystal;
        logic debug_mode;
        logic boundary_scan_mode;
    } rdms_mode_t;

    // Ring clock and boundary scan until a strap is sampled
    localparam rdms_mode_t MODE_AFTER_RESET = '{
        system_base_clock_crystal: CLK_SEL_RING,
        debug_mode: 1'h0,
        boundary_scan_mode: 1'h1
    };

    typedef struct packed {
        logic external;
        logic software;
        logic watchdog;
    } rdms_req_t;
endpackage
`default_nettype wire

// file: hw/rdms_sync.sv
`timescale 1ns/10ps
`default_nettype none
module rdms_sync (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // Reset request in, synchronised release out
    input wire logic i_assert,
    output logic o_reset
);
    logic [rdms_pkg::SYNC_STAGES-1:0] stage_r;
    logic [rdms_pkg::SYNC_STAGES-1:0] stage_nxt;

    // Assertion is immediate, release walks through the stages
    always_comb begin
        stage_nxt = {stage_r[rdms_pkg::SYNC_STAGES-2:0], 1'b0};
        if (i_assert) begin
            stage_nxt = '1;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            stage_r <= '1;
        end else begin
            stage_r <= stage_nxt;
        end
    end

    assign o_reset = stage_r[rdms_pkg::SYNC_STAGES-1] | i_assert;
endmodule
`default_nettype wire

// file: testbench/rdms_top_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module rdms_checker (
    // Design ports
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_ext_reset_n,
    input wire logic i_test_port_mode_strap,
    input wire logic i_test_reset_n,
    input wire logic i_osc_stable,
    input wire logic i_flash_stable,
    input wire logic [rdms_pkg::NUM_DOMAINS-1:0] i_domain_reset_req,
    input wire logic o_chip_reset,
    input wire logic [rdms_pkg::NUM_DOMAINS-1:0] o_domain_reset,
    input wire logic o_scan_reset,
    input wire rdms_pkg::rdms_mode_t o_mode,
    input wire logic [3:0] o_reset_cause
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    ext_req_a: assert property (
        !i_ext_reset_n |-> o_chip_reset) else $error("no chip reset");
    stable_rel_a: assert property (
        $fell(o_chip_reset) |-> $past(i_osc_stable, 3)
        && $past(i_flash_stable, 3)) else $error("early release");
    strap_cap_a: assert property (
        !i_ext_reset_n |=> o_mode.debug_mode
        == !$past(i_test_port_mode_strap)) else $error("strap");
    crystal_a: assert property (
        o_mode.system_base_clock_crystal == o_mode.debug_mode)
        else $error("clock source");
    tap_mode_a: assert property (
        o_mode.debug_mode != o_mode.boundary_scan_mode) else $error("mode");
    scan_rst_a: assert property (
        !i_test_reset_n |=> o_scan_reset) else $error("scan reset");
    dom_rst_a: assert property (
        (i_domain_reset_req & ~o_domain_reset) == '0) else $error("domain");
    cause_ext_a: assert property (
        !i_ext_reset_n |=> o_reset_cause[1]) else $error("cause");
endmodule
bind rdms_top rdms_checker i_chk (.i_core_clk, .i_reset, .i_ext_reset_n,
    .i_test_port_mode_strap, .i_test_reset_n, .i_osc_stable, .i_flash_stable,
    .i_domain_reset_req, .o_chip_reset, .o_domain_reset, .o_scan_reset,
    .o_mode, .o_reset_cause);
`default_nettype wire

// file: testbench/rdms_board.sv
`timescale 1ns/10ps
`default_nettype none
module rdms_board (
    // Button and probe presence
    input wire logic i_press,
    input wire logic i_probe,
    // Pins
    output logic o_ext_reset_n,
    output logic o_strap
);
    assign o_ext_reset_n = !i_press;
    // Pulled up, so high without a probe
    assign o_strap = !i_probe;
endmodule
`default_nettype wire

// file: testbench/reset_and_debug_mode_select_test.sv
`timescale 1ns/10ps
`default_nettype none
module reset_and_debug_mode_select_test;
    logic clk = 1'b0, rst = 1'b1, prs = 1'b0, prb = 1'b0, trn = 1'b1;
    logic osc = 1'b1, fl = 1'b0, sw = 1'b0, wd = 1'b0, ern, stp, chip, scan;
    logic [7:0] dq = 8'h00, dom;
    logic [3:0] cause;
    rdms_pkg::rdms_mode_t mode;
    int err_count = 0, samples_checked = 0, cyc = 0;
    rdms_board i_brd (.i_press(prs), .i_probe(prb), .o_ext_reset_n(ern),
        .o_strap(stp));
    rdms_top i_dut (.i_core_clk(clk), .i_reset(rst), .i_ext_reset_n(ern),
        .i_test_port_mode_strap(stp), .i_test_reset_n(trn),
        .i_osc_stable(osc), .i_flash_stable(fl), .i_soft_reset(sw),
        .i_watchdog_reset(wd), .i_domain_reset_req(dq), .o_chip_reset(chip),
        .o_domain_reset(dom), .o_scan_reset(scan), .o_mode(mode),
        .o_reset_cause(cause));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [7:0] s, e, input string n);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic conclude;
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            conclude;
        end
    end
    task automatic t_power;
        repeat (12) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        chk(chip, 8'h01, "power hold");
        fl = 1'b1;
        repeat (4) @(negedge clk);
        chk(chip, 8'h00, "power release");
        chk(cause, rdms_pkg::CAUSE_POWER_UP, "power cause");
        chk(mode, 8'h01, "power mode");
    endtask
    task automatic t_ext(input logic p);
        int n = 0;
        {prs, prb, osc, fl} = {1'b1, p, 2'h0};
        repeat (3) @(negedge clk);
        chk(chip, 8'h01, "chip");
        chk(cause, rdms_pkg::CAUSE_EXTERNAL, "cause");
        prs = 1'b0;
        repeat (6) @(negedge clk);
        chk(chip, 8'h01, "hold");
        osc = 1'b1;
        repeat (4) @(negedge clk);
        chk(chip, 8'h01, "flash hold");
        fl = 1'b1;
        while (chip === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(8'(n), 8'h03, "release");
        chk(mode, p ? 3'h6 : 3'h1, "mode");
        chk(cause, rdms_pkg::CAUSE_EXTERNAL, "cause kept");
    endtask
    task automatic t_domain;
        for (int i = 0; i < 8; i++) begin
            dq = 8'h01 << i;
            repeat (4) @(negedge clk);
            chk(dom, dq, "domain");
        end
        dq = 8'h00;
        @(negedge clk);
        chk(dom, 8'h80, "domain hold");
        @(negedge clk);
        chk(dom, 8'h00, "domain release");
    endtask
    task automatic t_scan;
        trn = 1'b0;
        @(negedge clk);
        chk({scan, chip}, 2'h2, "scan");
        trn = 1'b1;
        @(negedge clk);
        chk(scan, 8'h00, "scan release");
    endtask
    task automatic t_cause;
        sw = 1'b1;
        @(negedge clk);
        chk(cause, rdms_pkg::CAUSE_SOFTWARE, "soft");
        {sw, wd} = 2'h1;
        repeat (2) @(negedge clk);
        chk(cause, rdms_pkg::CAUSE_WATCHDOG, "wdog");
    endtask
    initial begin
        t_power;
        t_ext(1'b1);
        t_ext(1'b0);
        t_domain;
        t_scan;
        t_cause;
        conclude;
    end
endmodule
`default_nettype wire
